// *** rtl/fcs_fault_collector.sv ***
// Fault collector: latches fault sources, applies per-source reactions,
// drives the two error outputs and guards debug access.
// Assumes all inputs are synchronous to ref_clk; the pad resolves the error pins.
//
// Notes on behaviour
// R1: Debug access enable low holds the test access controller in reset.
// R2: Debug access enable high releases the test access controller.
// R3: System keeps debug access enable low during boot.
// R4: Debug mode while access enable is low raises a fault.
// R5: After erroneous debug entry no debug command is accepted.
// R6: Test mode entry may raise a fault when enabled.
// R7: Freeze bit clear keeps collection running in debug mode.
// R8: Checker results and module errors are fault inputs.
// R9: Each fault source has its own reaction field.
// R10: Reactions are none, interrupt, non-maskable interrupt, reset, external.
// R11: Each fault drives the device to its configured safe state.
// R12: Collection and reaction run in hardware alone.
// R13: Supervisor resets when the collector fails to react or when configuration state reaches its limit.
// R14: Configuration state lasts at most 8000 oscillator cycles.
// R15: Error outputs are tristated during reset.
// R16: External monitor watches error outputs and holds the system safe.
// R17: Reaction registers are writable only in configuration state.
// R18: Test mode makes pin 0 an input and pin 1 a driven bit.
// R19: Supervisor counts from configuration entry and forces reset at limit.
// R20: External faults hold the error outputs at fault level until cleared (not in pin test mode, where pin 0 is released and pin 1 follows its drive bit).
//
// Implementation choices: the register offsets and the plain strobed port.
`default_nettype none

module fcs_fault_collector #(
    parameter int CFG_LIMIT = fcs_pkg::FCS_CFG_LIMIT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic irc_tick,
    input wire logic [fcs_pkg::FCS_AW-1:0] addr,
    input wire logic [fcs_pkg::FCS_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [fcs_pkg::FCS_DW-1:0] rdata,
    input wire logic [fcs_pkg::FCS_NEXT-1:0] fault_in,
    input wire logic debug_access_enable,
    input wire logic debug_mode_active,
    input wire logic test_mode_active,
    input wire logic jtag_cmd_valid,
    output logic jtag_cmd_ok,
    output logic tac_reset_n,
    output logic irq,
    output logic nmi,
    output logic reset_req,
    input wire logic fault_out0_i,
    output logic fault_out0_o,
    output logic fault_out0_oe_n,
    output logic fault_out1_o,
    output logic fault_out1_oe_n
);
    import fcs_pkg::*;

    // ***********************************************************
    // Helpers
    // ***********************************************************
    function automatic logic [FCS_NSRC-1:0] kind_mask(input logic [FCS_REACT_W-1:0] r,
                                                     input logic [2:0] k);
        logic [FCS_NSRC-1:0] m;
        m = '0;
        for (int i = 0; i < FCS_NSRC; i++) begin
            m[i] = (r[i*FCS_RW +: FCS_RW] == k);
        end
        return m;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ***********************************************************
    // State
    // ***********************************************************
    fcs_state_e state_q;
    logic [FCS_CTRL_W-1:0] ctrl_q;
    logic [FCS_REACT_W-1:0] react_q;
    logic [FCS_NSRC-1:0] fault_q;
    logic [FCS_NSRC-1:0] fault_d;
    logic [FCS_NSRC-1:0] fault_set;
    logic [FCS_NSRC-1:0] fault_clr;
    logic [FCS_NSRC-1:0] m_none;
    logic [FCS_NSRC-1:0] m_irq;
    logic [FCS_NSRC-1:0] m_nmi;
    logic [FCS_NSRC-1:0] m_rst;
    logic [FCS_NSRC-1:0] m_ext;
    logic [FCS_DW-1:0] rdata_q;
    logic lock_q;
    logic tac_q;
    logic irq_q;
    logic nmi_q;
    logic rst_pulse_q;
    logic rst_hold_q;
    logic ext_q;
    logic ext_d;
    logic fault_pin0_input_level_q;
    logic out0_q;
    logic out0_oe_n_q;
    logic out1_q;
    logic out1_oe_n_q;
    logic dbg_fault;
    logic frozen;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_fault;
    logic wr_react;

    fcs_sup_if sup_if ();

    fcs_output_supervisor #(
        .CFG_LIMIT(CFG_LIMIT)
    ) u_sup (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .irc_tick(irc_tick),
        .sup(sup_if.supervisor)
    );

    // ***********************************************************
    // Fault sources
    // ***********************************************************
    assign dbg_fault = debug_mode_active && !debug_access_enable; // see R4
    assign frozen = ctrl_q[FCS_CTRL_FREEZE] && debug_mode_active; // see R7

    always_comb begin
        fault_set = '0;
        fault_set[FCS_NEXT-1:0] = frozen ? '0 : fault_in; // see R8
        fault_set[FCS_SRC_DEBUG] = dbg_fault; // see R4
        fault_set[FCS_SRC_TEST] = test_mode_active && ctrl_q[FCS_CTRL_TFEN]; // see R6
    end

    assign wr_ctrl = wr && hit(addr, FCS_OFF_CTRL);
    assign wr_cmd = wr && hit(addr, FCS_OFF_CMD);
    assign wr_fault = wr && hit(addr, FCS_OFF_FAULT);
    assign wr_react = wr && hit(addr, FCS_OFF_REACT) && state_q == fcs_config; // see R17

    assign fault_clr = wr_fault ? wdata[FCS_NSRC-1:0] : '0;
    // A new event wins over a clear in the same cycle
    assign fault_d = (fault_q & ~fault_clr) | fault_set;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= '0;
        end else if (clk_en) begin
            fault_q <= fault_d; // see R12
        end
    end

    // ***********************************************************
    // Reaction decode
    // ***********************************************************
    assign m_none = kind_mask(react_q, FCS_RX_NONE);
    assign m_irq = kind_mask(react_q, FCS_RX_IRQ); // see R9 see R10
    assign m_nmi = kind_mask(react_q, FCS_RX_NMI);
    assign m_rst = kind_mask(react_q, FCS_RX_RST);
    assign m_ext = kind_mask(react_q, FCS_RX_EXT);
    assign ext_d = |(fault_d & m_ext);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
            nmi_q <= 1'b0;
            rst_pulse_q <= 1'b0;
            rst_hold_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(fault_d & m_irq); // see R10 see R11
            nmi_q <= |(fault_d & m_nmi);
            rst_pulse_q <= |(fault_set & ~fault_q & m_rst); // see R11
            rst_hold_q <= |(fault_d & m_rst);
            ext_q <= ext_d; // see R20
        end
    end

    assign irq = irq_q;
    assign nmi = nmi_q;
    assign reset_req = rst_pulse_q || sup_if.sup_reset;

    assign sup_if.cfg_state = state_q == fcs_config;
    assign sup_if.fault_pend = |(fault_q & ~m_none);
    assign sup_if.reacting = irq_q || nmi_q || rst_hold_q || ext_q;

    // ***********************************************************
    // Operating state
    // ***********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= fcs_normal;
        end else if (clk_en) begin
            unique case (state_q)
                fcs_normal: begin
                    if (wr_cmd && wdata[FCS_CMD_ENTER]) begin
                        state_q <= fcs_config;
                    end else if (ext_d) begin
                        state_q <= fcs_fault;
                    end
                end
                fcs_config: begin
                    if (sup_if.sup_reset || (wr_cmd && wdata[FCS_CMD_LEAVE])) begin
                        state_q <= fcs_normal;
                    end
                end
                fcs_fault: begin
                    if (!ext_d) begin
                        state_q <= fcs_normal;
                    end
                end
            endcase
        end
    end

    // ***********************************************************
    // Software registers
    // ***********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= FCS_CTRL_RST;
        end else if (clk_en && wr_ctrl) begin
            ctrl_q <= wdata[FCS_CTRL_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            react_q <= FCS_REACT_RST;
        end else if (clk_en && wr_react) begin
            react_q <= wdata[FCS_REACT_W-1:0]; // see R17
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (clk_en && rd) begin
            rdata_q <= '0;
            unique case (addr)
                FCS_OFF_CTRL: rdata_q[FCS_CTRL_W-1:0] <= ctrl_q;
                FCS_OFF_STAT: begin
                    rdata_q[1:0] <= state_q;
                    rdata_q[FCS_STAT_LOCK] <= lock_q;
                    rdata_q[FCS_STAT_FAULT_PIN0_INPUT_LEVEL] <= fault_pin0_input_level_q; // see R18
                    rdata_q[FCS_STAT_SUP] <= sup_if.sup_reset;
                end
                FCS_OFF_FAULT: rdata_q[FCS_NSRC-1:0] <= fault_q;
                FCS_OFF_REACT: rdata_q[FCS_REACT_W-1:0] <= react_q;
                default: rdata_q <= '0;
            endcase
        end
    end

    assign rdata = rdata_q;

    // ***********************************************************
    // Debug access guard
    // ***********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tac_q <= 1'b0;
        end else if (clk_en) begin
            tac_q <= debug_access_enable; // see R1 see R2
        end
    end

    // Cleared only by device reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= 1'b0;
        end else if (clk_en && dbg_fault) begin
            lock_q <= 1'b1; // see R5
        end
    end

    assign tac_reset_n = tac_q;
    assign jtag_cmd_ok = jtag_cmd_valid && tac_q && !lock_q; // see R5

    // ***********************************************************
    // Error pins
    // ***********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out0_q <= 1'b0;
            out1_q <= 1'b0;
            out0_oe_n_q <= 1'b1; // see R15
            out1_oe_n_q <= 1'b1;
            fault_pin0_input_level_q <= 1'b0;
        end else if (clk_en) begin
            fault_pin0_input_level_q <= fault_out0_i;
            out1_oe_n_q <= 1'b0;
            if (ctrl_q[FCS_CTRL_FIRST_ERROR_PIN_TEST_MODE]) begin
                out0_oe_n_q <= 1'b1; // see R18
                out0_q <= 1'b0;
                out1_q <= ctrl_q[FCS_CTRL_FAULT_PIN1_OUTPUT_DRIVE];
            end else begin
                out0_oe_n_q <= 1'b0;
                out0_q <= !ext_d; // see R20
                out1_q <= !ext_d;
            end
        end
    end

    assign fault_out0_o = out0_q;
    assign fault_out0_oe_n = out0_oe_n_q;
    assign fault_out1_o = out1_q;
    assign fault_out1_oe_n = out1_oe_n_q;

    // ***********************************************************
    // Checks
    // ***********************************************************
    property p_tac_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && !debug_access_enable |=> !tac_reset_n;
    endproperty
    a_tac_hold: assert property (p_tac_hold) else $error("tap not held in reset"); // see R1

    property p_tac_free;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && debug_access_enable |=> tac_reset_n;
    endproperty
    a_tac_free: assert property (p_tac_free) else $error("tap not released"); // see R2

    property p_dbg_fault;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && debug_mode_active && !debug_access_enable |=> fault_q[FCS_SRC_DEBUG] && lock_q;
    endproperty
    a_dbg_fault: assert property (p_dbg_fault) else $error("debug entry not flagged"); // see R4

    property p_lock;
        @(posedge ref_clk) disable iff (!reset_n)
        lock_q |-> !jtag_cmd_ok;
    endproperty
    a_lock: assert property (p_lock) else $error("debug command after lock"); // see R5

    property p_test_fault;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && test_mode_active && ctrl_q[FCS_CTRL_TFEN] |=> fault_q[FCS_SRC_TEST];
    endproperty
    a_test_fault: assert property (p_test_fault) else $error("test mode not flagged"); // see R6

    property p_no_freeze;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && !ctrl_q[FCS_CTRL_FREEZE] && fault_in[0] |=> fault_q[0];
    endproperty
    a_no_freeze: assert property (p_no_freeze) else $error("fault lost in debug"); // see R7

    property p_irq;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && !frozen && fault_in[0] && react_q[FCS_RW-1:0] == FCS_RX_IRQ |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt reaction missing"); // see R10

    property p_cfg_lock;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && wr && addr == FCS_OFF_REACT && state_q != fcs_config |=> $stable(react_q);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("reaction write not refused"); // see R17

    property p_first_error_pin_test_mode;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && ctrl_q[FCS_CTRL_FIRST_ERROR_PIN_TEST_MODE] |=>
            fault_out0_oe_n && fault_out1_o == $past(ctrl_q[FCS_CTRL_FAULT_PIN1_OUTPUT_DRIVE]);
    endproperty
    a_first_error_pin_test_mode: assert property (p_first_error_pin_test_mode) else $error("pin test mode wrong"); // see R18

    property p_ext;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && ext_d && !ctrl_q[FCS_CTRL_FIRST_ERROR_PIN_TEST_MODE] |=>
            !fault_out0_o && !fault_out1_o && !fault_out0_oe_n;
    endproperty
    a_ext: assert property (p_ext) else $error("error pins not at fault level"); // see R20

    c_config: cover property (@(posedge ref_clk) disable iff (!reset_n) state_q == fcs_config);
    c_ext: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(ext_q));
    c_lock: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(lock_q));
endmodule

`default_nettype wire

// *** rtl/fcs_output_supervisor.sv ***
// Secondary reset path watching the fault collector.
// Assumes irc_tick pulses once per internal RC oscillator cycle, in step with ref_clk.
`default_nettype none

module fcs_output_supervisor #(
    parameter int CFG_LIMIT = fcs_pkg::FCS_CFG_LIMIT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic irc_tick,
    fcs_sup_if.supervisor sup
);
    import fcs_pkg::*;

    localparam logic [FCS_CNT_W-1:0] CFG_LIM = FCS_CNT_W'(CFG_LIMIT);
    localparam logic [FCS_CNT_W-1:0] RX_LIM = FCS_CNT_W'(FCS_REACT_LIMIT_CYC);

    logic [FCS_CNT_W-1:0] cfg_cnt_q;
    logic [FCS_CNT_W-1:0] rx_cnt_q;
    logic sup_reset_q;
    logic cfg_over;
    logic rx_over;

    assign cfg_over = sup.cfg_state && (cfg_cnt_q >= CFG_LIM);
    assign rx_over = rx_cnt_q >= RX_LIM;
    assign sup.sup_reset = sup_reset_q;

    // ***********************************************************
    // Time spent in configuration state
    // ***********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_cnt_q <= '0;
        end else if (clk_en) begin
            if (!sup.cfg_state) begin
                cfg_cnt_q <= '0;
            end else if (irc_tick && !cfg_over) begin
                cfg_cnt_q <= cfg_cnt_q + FCS_CNT_W'(1); // see R19
            end
        end
    end

    // ***********************************************************
    // Pending fault without any reaction
    // ***********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_cnt_q <= '0;
        end else if (clk_en) begin
            if (!sup.fault_pend || sup.reacting) begin
                rx_cnt_q <= '0;
            end else if (irc_tick && !rx_over) begin
                rx_cnt_q <= rx_cnt_q + FCS_CNT_W'(1); // see R13
            end
        end
    end

    // Held until the device reset takes effect
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sup_reset_q <= 1'b0;
        end else if (clk_en && (cfg_over || rx_over)) begin
            sup_reset_q <= 1'b1; // see R13 see R14 see R19
        end
    end

    // ***********************************************************
    // Checks
    // ***********************************************************
    property p_cfg_limit;
        @(posedge ref_clk) disable iff (!reset_n)
        clk_en && sup.cfg_state && cfg_cnt_q >= CFG_LIM |=> sup_reset_q;
    endproperty
    a_cfg_limit: assert property (p_cfg_limit) else $error("config limit not enforced"); // see R14

    property p_only_on_cause;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(sup_reset_q) |-> $past(cfg_over) || $past(rx_over);
    endproperty
    a_only_on_cause: assert property (p_only_on_cause) else $error("stray reset"); // see R13

    c_cfg_timeout: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(sup_reset_q));
endmodule

`default_nettype wire

// *** rtl/fcs_pkg.sv ***
// Constants, register map and state type of the fault collection unit.
// Assumes a single ref_clk domain and a plain strobe register port.
`default_nettype none

package fcs_pkg;
    // ***********************************************************
    // Fault sources and reactions
    // ***********************************************************
    localparam int FCS_NEXT = 8;
    localparam int FCS_NSRC = 10;
    localparam int FCS_SRC_DEBUG = 8;
    localparam int FCS_SRC_TEST = 9;
    localparam int FCS_RW = 3;
    localparam int FCS_REACT_W = 30;
    localparam logic [2:0] FCS_RX_NONE = 3'h0;
    localparam logic [2:0] FCS_RX_IRQ = 3'h1;
    localparam logic [2:0] FCS_RX_NMI = 3'h2;
    localparam logic [2:0] FCS_RX_RST = 3'h3;
    localparam logic [2:0] FCS_RX_EXT = 3'h4;

    // ***********************************************************
    // Register map
    // ***********************************************************
    localparam int FCS_AW = 8;
    localparam int FCS_DW = 32;
    localparam logic [7:0] FCS_OFF_CTRL = 8'h00;
    localparam logic [7:0] FCS_OFF_CMD = 8'h04;
    localparam logic [7:0] FCS_OFF_STAT = 8'h08;
    localparam logic [7:0] FCS_OFF_FAULT = 8'h0C;
    localparam logic [7:0] FCS_OFF_REACT = 8'h10;
    localparam int FCS_CTRL_FREEZE = 0;
    localparam int FCS_CTRL_TFEN = 1;
    localparam int FCS_CTRL_FIRST_ERROR_PIN_TEST_MODE = 2;
    localparam int FCS_CTRL_FAULT_PIN1_OUTPUT_DRIVE = 3;
    localparam int FCS_CTRL_W = 4;
    localparam int FCS_CMD_ENTER = 0;
    localparam int FCS_CMD_LEAVE = 1;
    localparam int FCS_STAT_LOCK = 2;
    localparam int FCS_STAT_FAULT_PIN0_INPUT_LEVEL = 3;
    localparam int FCS_STAT_SUP = 4;
    localparam logic [3:0] FCS_CTRL_RST = 4'h0;
    localparam logic [29:0] FCS_REACT_RST = 30'h0000_0000;

    // ***********************************************************
    // Supervisor limits, in oscillator cycles
    // ***********************************************************
    localparam int FCS_CFG_LIMIT_CYC = 8000;
    localparam int FCS_REACT_LIMIT_CYC = 16;
    localparam int FCS_CNT_W = 14;

    typedef enum logic [1:0] {fcs_normal, fcs_config, fcs_fault} fcs_state_e;
endpackage

`default_nettype wire

// *** rtl/fcs_sup_if.sv ***
// Link between the fault collector and its output supervisor.
// Assumes both ends run on ref_clk.
`default_nettype none

interface fcs_sup_if;
    logic cfg_state;
    logic fault_pend;
    logic reacting;
    logic sup_reset;
    modport collector(output cfg_state, output fault_pend, output reacting, input sup_reset);
    modport supervisor(input cfg_state, input fault_pend, input reacting, output sup_reset);
endinterface

`default_nettype wire

// *** test/fcs_ext_monitor.sv ***
// Model of the external monitor watching both error pins.
// Assumes the bench may drive pin 0 while the unit releases it.
`default_nettype none

module fcs_ext_monitor (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic o0,
    input wire logic oe0_n,
    input wire logic o1,
    input wire logic oe1_n,
    input wire logic drv_en,
    input wire logic drv_val,
    output logic pin0,
    output var logic safe_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q;
    // A released pin without pull shows the inverse of its last level
    always_comb begin
        if (!oe0_n) begin
            pin0 = o0;
        end else if (drv_en) begin
            pin0 = drv_val;
        end else begin
            pin0 = ~last_q;
        end
    end
    always_ff @(posedge ref_clk) begin
        last_q <= pin0;
    end
    // Any driven fault level forces and holds the system safe state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            safe_q <= 1'b0;
        end else if ((!oe0_n && !o0) || (!oe1_n && !o1)) begin
            safe_q <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the fault collector and its monitor model.
// Assumes fcs_pkg, the link interface and the collector are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fcs_pkg::*;
    localparam int LIM = 20;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic tick = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [7:0] fault_in = '0;
    logic dae = 1'b0;
    logic dbg = 1'b0;
    logic tst = 1'b0;
    logic jv = 1'b0;
    logic drv_en = 1'b0;
    logic drv_val = 1'b0;
    logic jok, tac_n, irq, nmi, rst_req, pin0, o0, oe0_n, o1, oe1_n, safe;
    int error_cnt = 0;
    int checked = 0;

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) tick <= ~tick;

    fcs_fault_collector #(.CFG_LIMIT(LIM)) u_fcs_fault_collector (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .irc_tick(tick),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fault_in(fault_in), .debug_access_enable(dae), .debug_mode_active(dbg),
        .test_mode_active(tst), .jtag_cmd_valid(jv), .jtag_cmd_ok(jok),
        .tac_reset_n(tac_n), .irq(irq), .nmi(nmi), .reset_req(rst_req),
        .fault_out0_i(pin0), .fault_out0_o(o0), .fault_out0_oe_n(oe0_n),
        .fault_out1_o(o1), .fault_out1_oe_n(oe1_n));
    fcs_ext_monitor u_fcs_ext_monitor (
        .ref_clk(ref_clk), .reset_n(reset_n), .o0(o0), .oe0_n(oe0_n), .o1(o1),
        .oe1_n(oe1_n), .drv_en(drv_en), .drv_val(drv_val), .pin0(pin0), .safe_q(safe));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        {rd, addr} <= {1'b1, a};
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        {reset_n, dae, dbg, tst, jv, drv_en, fault_in} <= '0;
        cyc(10);
        chk({oe0_n, oe1_n, tac_n}, 3'h6);
        @(posedge ref_clk) reset_n <= 1'b1;
        cyc(1);
        chk({oe0_n, oe1_n, o0, o1, tac_n}, 5'h06);
    endtask
    task automatic t_react();
        logic [4:0] ex [4];
        ex = '{5'h13, 5'h0B, 5'h07, 5'h00};
        wr_reg(FCS_OFF_CMD, 2'h1);
        rd_chk(FCS_OFF_STAT, 2'h3, 2'h1);
        wr_reg(FCS_OFF_REACT, 12'h8D1);
        rd_chk(FCS_OFF_REACT, '1, 12'h8D1);
        wr_reg(FCS_OFF_CMD, 2'h2);
        wr_reg(FCS_OFF_REACT, 1'h0);
        rd_chk(FCS_OFF_REACT, '1, 12'h8D1);
        rd_chk(8'h40, '1, 1'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk) fault_in <= 8'h01 << k;
            cyc(1);
            chk({irq, nmi, rst_req, o0, o1}, ex[k]);
            @(posedge ref_clk) fault_in <= 8'h00;
            cyc(2);
            chk({rst_req, o0, o1}, {1'b0, ex[k][1:0]});
            wr_reg(FCS_OFF_FAULT, 32'h0000_0001 << k);
            cyc(1);
            chk({irq, nmi, rst_req, o0, o1}, 5'h03);
        end
        chk(safe, 1'h1);
    endtask
    task automatic t_test();
        wr_reg(FCS_OFF_CTRL, 2'h2);
        @(posedge ref_clk) tst <= 1'b1;
        cyc(2);
        @(posedge ref_clk) tst <= 1'b0;
        rd_chk(FCS_OFF_FAULT, 10'h3FF, 10'h200);
        wr_reg(FCS_OFF_FAULT, 10'h200);
        wr_reg(FCS_OFF_CTRL, 1'h0);
        @(posedge ref_clk) tst <= 1'b1;
        cyc(2);
        @(posedge ref_clk) tst <= 1'b0;
        rd_chk(FCS_OFF_FAULT, 10'h3FF, 1'h0);
    endtask
    task automatic t_pin();
        wr_reg(FCS_OFF_CTRL, 4'h4);
        @(posedge ref_clk) drv_en <= 1'b1;
        cyc(1);
        chk({oe0_n, o1}, 2'h2);
        rd_chk(FCS_OFF_STAT, 4'h8, 1'h0);
        @(posedge ref_clk) drv_val <= 1'b1;
        rd_chk(FCS_OFF_STAT, 4'h8, 4'h8);
        wr_reg(FCS_OFF_CTRL, 4'hC);
        cyc(1);
        chk(o1, 1'h1);
        wr_reg(FCS_OFF_CTRL, 1'h0);
        @(posedge ref_clk) drv_en <= 1'b0;
    endtask
    task automatic t_sup();
        int n;
        n = 0;
        rd_chk(FCS_OFF_STAT, 8'h10, 1'h0);
        wr_reg(FCS_OFF_CMD, 2'h1);
        while (rst_req !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(n >= 2 * LIM && n <= 2 * LIM + 1, 1'h1);
        cyc(3);
        chk(rst_req, 1'h1);
        rd_chk(FCS_OFF_STAT, 8'h10, 8'h10);
        chk(rdata[1:0] !== 2'h1, 1'h1);
    endtask
    task automatic t_debug();
        chk(tac_n, 1'h0);
        @(posedge ref_clk) {dae, jv} <= 2'h3;
        cyc(2);
        chk({tac_n, jok}, 2'h3);
        @(posedge ref_clk) {dbg, fault_in} <= {1'b1, 8'h20};
        cyc(2);
        @(posedge ref_clk) dae <= 1'b0;
        cyc(3);
        chk({tac_n, jok}, 2'h0);
        rd_chk(FCS_OFF_FAULT, 10'h3FF, 10'h120);
        @(posedge ref_clk) dae <= 1'b1;
        cyc(2);
        chk({tac_n, jok}, 2'h2);
        rd_chk(FCS_OFF_STAT, 4'h4, 4'h4);
        wr_reg(FCS_OFF_CTRL, 1'h1);
        @(posedge ref_clk) fault_in <= 8'h40;
        cyc(2);
        rd_chk(FCS_OFF_FAULT, 10'h3FF, 10'h120);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_react();
        t_test();
        t_pin();
        t_sup();
        do_reset();
        t_debug();
        summarize();
    end
    initial begin
        #(40 * 3000);
        error_cnt++;
        summarize();
    end
endmodule

`default_nettype wire
